// File: design/sbwr_status_bank.sv
// Status and fault register bank with busy-register write rejection.
// Assumes a host transaction port already checked for protocol and PEC errors,
// and live measurement inputs arriving from logic on the same clock.
//
// Operation
// [R01] Registers form blocks, each with a busy input, so in-use content cannot change.
// [R02] A valid write to a register whose block is busy is discarded unchanged.
// [R03] A discarded write sets the write-reject alert bit in the comm status word.
// [R04] Host software should confirm the internal process finished before writing.
// [R05] Offset zero is a read-only word with model in bits 15:4 and revision in 3:0.
// [R06] The over-voltage word flags cells in bits 14:1, with bits 15 and 0 reading zero.
// [R07] Highest cell index sits in bits 11:8 and lowest cell index in bits 3:0 of 0x0A.
// [R08] Unused bits read as zero and never store written data.
`timescale 1ns/1ps
`default_nettype none
`include "sbwr_regs.svh"
module sbwr_status_bank #(
  parameter logic [11:0] MODEL_ID    = 12'h123,  // Arbitrary value.
  parameter logic [3:0]  REVISION_ID = 4'h1      // Arbitrary value.
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             req_valid,
  input  wire logic             req_write,
  input  wire logic [7:0]       req_addr,
  input  wire logic [15:0]      req_wdata,
  input  wire logic             busy_config,
  input  wire logic             busy_status,
  input  wire logic [15:0]      stat_pri_set,
  input  wire logic [15:0]      stat_comm_set,
  input  wire logic [15:0]      stat_bal_set,
  input  wire logic [15:0]      fault_pri_set,
  input  wire logic [15:0]      fault_sec_set,
  input  wire logic [15:0]      alert_sum_in,
  input  wire logic [15:0]      cell_over_flags,
  input  wire logic [15:0]      cell_under_flags,
  input  wire logic [3:0]       highest_cell_index,
  input  wire logic [3:0]       lowest_cell_index,
  input  wire logic [3:0]       aux_prot_in,
  input  wire logic [3:0]       aux_over_in,
  input  wire logic [3:0]       aux_under_in,
  output logic                  rsp_valid,
  output logic      [15:0]      rsp_rdata,
  output logic                  rsp_rejected,
  output logic                  write_reject_alert
);
  sbwr_pkg::sbwr_state_t state_r;
  sbwr_pkg::sbwr_state_t state_nxt;
  logic [7:0]  addr_r;
  logic [15:0] wdata_r;
  logic        write_r;
  logic [15:0] chain_r;
  logic [15:0] ovf_r, uvf_r, ext_r, auxp_r, auxo_r, auxu_r, sum_r;
  logic [15:0] stat_pri_v, stat_comm_v, stat_bal_v, fault_pri_v, fault_sec_v;

  // Block membership: offset 1 is the config block, 2 to 6 the clearable status block.
  wire hit_cfg    = (addr_r == `SBWR_OFF_CHAIN_ADDR);
  wire hit_stat   = (addr_r >= `SBWR_OFF_STAT_PRI) && (addr_r <= `SBWR_OFF_FAULT_SEC);
  wire blk_busy   = (hit_cfg && busy_config) || (hit_stat && busy_status);     // [R01]
  wire in_check   = (state_r == sbwr_pkg::SBWR_CHECK);
  wire wr_go      = in_check && write_r && !blk_busy;                         // [R02]
  wire wr_reject  = in_check && write_r && blk_busy && (hit_cfg || hit_stat); // [R02]
  wire clr_pri    = wr_go && (addr_r == `SBWR_OFF_STAT_PRI);
  wire clr_comm   = wr_go && (addr_r == `SBWR_OFF_STAT_COMM);
  wire clr_bal    = wr_go && (addr_r == `SBWR_OFF_STAT_BAL);
  wire clr_fpri   = wr_go && (addr_r == `SBWR_OFF_FAULT_PRI);
  wire clr_fsec   = wr_go && (addr_r == `SBWR_OFF_FAULT_SEC);
  wire wr_chain   = wr_go && hit_cfg;
  wire [15:0] comm_set = stat_comm_set | {15'h0000, wr_reject};               // [R03]
  // Next value of the alert bit, so the output pin moves in step with the stored bit.
  wire comm_alert_nxt = comm_set[`SBWR_REJECT_BIT] |
                        (stat_comm_v[`SBWR_REJECT_BIT] & ~(clr_comm & wdata_r[`SBWR_REJECT_BIT]));

  // Clearable alert words, one instance per register.
  sbwr_hold_reg u_pri (.clk(clk), .rst(rst), .ce(ce), .mask(16'hFFFF),
    .set_bits(stat_pri_set), .clr_en(clr_pri), .clr_bits(wdata_r), .value(stat_pri_v));
  sbwr_hold_reg u_comm (.clk(clk), .rst(rst), .ce(ce), .mask(`SBWR_STAT_COMM_MASK),
    .set_bits(comm_set), .clr_en(clr_comm), .clr_bits(wdata_r), .value(stat_comm_v));
  sbwr_hold_reg u_bal (.clk(clk), .rst(rst), .ce(ce), .mask(`SBWR_STAT_BAL_MASK),
    .set_bits(stat_bal_set), .clr_en(clr_bal), .clr_bits(wdata_r), .value(stat_bal_v));
  sbwr_hold_reg u_fpri (.clk(clk), .rst(rst), .ce(ce), .mask(16'hFFFF),
    .set_bits(fault_pri_set), .clr_en(clr_fpri), .clr_bits(wdata_r), .value(fault_pri_v));
  sbwr_hold_reg u_fsec (.clk(clk), .rst(rst), .ce(ce), .mask(`SBWR_FAULT_SEC_MASK),
    .set_bits(fault_sec_set), .clr_en(clr_fsec), .clr_bits(wdata_r), .value(fault_sec_v));

  // Read selection; unused bits are masked to zero and unmapped offsets read zero.
  wire [15:0] id_word = {MODEL_ID, REVISION_ID};                              // [R05]
  wire [15:0] rd_word =
    (addr_r == `SBWR_OFF_MODEL_REV)  ? id_word :
    (addr_r == `SBWR_OFF_CHAIN_ADDR) ? chain_r :
    (addr_r == `SBWR_OFF_STAT_PRI)   ? stat_pri_v :
    (addr_r == `SBWR_OFF_STAT_COMM)  ? stat_comm_v :
    (addr_r == `SBWR_OFF_STAT_BAL)   ? stat_bal_v :
    (addr_r == `SBWR_OFF_FAULT_PRI)  ? fault_pri_v :
    (addr_r == `SBWR_OFF_FAULT_SEC)  ? fault_sec_v :
    (addr_r == `SBWR_OFF_ALERT_SUM)  ? sum_r :
    (addr_r == `SBWR_OFF_CELL_OV)    ? ovf_r :                                // [R06]
    (addr_r == `SBWR_OFF_CELL_UV)    ? uvf_r :
    (addr_r == `SBWR_OFF_EXT_CELL)   ? ext_r :                                // [R07]
    (addr_r == `SBWR_OFF_AUX_PROT)   ? auxp_r :
    (addr_r == `SBWR_OFF_AUX_OV)     ? auxo_r :
    (addr_r == `SBWR_OFF_AUX_UV)     ? auxu_r : 16'h0000;                     // [R08]

  // Transaction sequencer: capture, check, answer.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      sbwr_pkg::SBWR_IDLE: begin
        if (req_valid) begin
          state_nxt = sbwr_pkg::SBWR_CHECK;
        end
      end
      sbwr_pkg::SBWR_CHECK: begin
        state_nxt = sbwr_pkg::SBWR_DONE;
      end
      default: begin
        state_nxt = sbwr_pkg::SBWR_IDLE;
      end
    endcase
  end

  // Request capture and sequencer state.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= sbwr_pkg::SBWR_IDLE;
      addr_r  <= 8'h00;
      wdata_r <= 16'h0000;
      write_r <= 1'b0;
    end else if (ce) begin
      state_r <= state_nxt;
      if (state_r == sbwr_pkg::SBWR_IDLE && req_valid) begin
        addr_r  <= req_addr;
        wdata_r <= req_wdata;
        write_r <= req_write;
      end
    end
  end

  // Live measurement words, sampled with unused bits forced to zero.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ovf_r  <= 16'h0000;
      uvf_r  <= 16'h0000;
      ext_r  <= 16'h0000;
      auxp_r <= 16'h0000;
      auxo_r <= 16'h0000;
      auxu_r <= 16'h0000;
      sum_r  <= 16'h0000;
    end else if (ce) begin
      ovf_r  <= cell_over_flags & `SBWR_CELL_MASK;                           // [R06]
      uvf_r  <= cell_under_flags & `SBWR_CELL_MASK;
      ext_r  <= {4'h0, highest_cell_index, 4'h0, lowest_cell_index};         // [R07]
      auxp_r <= {12'h000, aux_prot_in};
      auxo_r <= {12'h000, aux_over_in};
      auxu_r <= {12'h000, aux_under_in};
      sum_r  <= alert_sum_in & `SBWR_ALERT_SUM_MASK;
    end
  end

  // Config word write; kept only when its block is idle.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chain_r <= `SBWR_RESET_WORD;
    end else if (ce && wr_chain) begin
      chain_r <= wdata_r & `SBWR_CHAIN_WR_MASK;                              // [R02]
    end
  end

  // Answer port, registered.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rsp_valid          <= 1'b0;
      rsp_rdata          <= 16'h0000;
      rsp_rejected       <= 1'b0;
      write_reject_alert <= 1'b0;
    end else if (ce) begin
      rsp_valid          <= in_check;
      rsp_rdata          <= (in_check && !write_r) ? rd_word : 16'h0000;
      rsp_rejected       <= wr_reject;                                       // [R03]
      write_reject_alert <= comm_alert_nxt;                                  // [R03]
    end
  end

  // A rejected config write leaves the stored word unchanged.
  a_reject_keeps_word: assert property (@(posedge clk) disable iff (rst) // [R02]
    (ce && wr_reject && hit_cfg) |=> $stable(chain_r))
    else $error("Rejected write changed the config word.");

  // A rejection raises the alert on the next cycle.
  a_reject_sets_alert: assert property (@(posedge clk) disable iff (rst) // [R03]
    (ce && wr_reject) |=> stat_comm_v[0])
    else $error("Rejection did not set the alert bit.");

  // The alert pin always shows the stored alert bit.
  a_alert_mirrors_bit: assert property (@(posedge clk) disable iff (rst) // [R03]
    write_reject_alert == stat_comm_v[`SBWR_REJECT_BIT])
    else $error("Alert pin differs from the stored alert bit.");

  // A write to a busy status block is answered as rejected.
  a_busy_blocks_write: assert property (@(posedge clk) disable iff (rst) // [R01]
    (ce && in_check && write_r && hit_stat && busy_status) |=> rsp_rejected)
    else $error("Write to a busy block not rejected.");

  // Identification reads are constant.
  a_id_read_value: assert property (@(posedge clk) disable iff (rst) // [R05]
    (ce && in_check && !write_r && addr_r == 8'h00) |=> rsp_rdata == {MODEL_ID, REVISION_ID})
    else $error("Identification read wrong.");

  // Over-voltage edge bits stay zero.
  a_ov_edges_zero: assert property (@(posedge clk) disable iff (rst) // [R06]
    ovf_r[15] == 1'b0 && ovf_r[0] == 1'b0)
    else $error("Unused over-voltage bit set.");

  // Extreme-cell word has only its two nibbles.
  a_ext_fields: assert property (@(posedge clk) disable iff (rst) // [R07]
    ce |=> ext_r == {4'h0, $past(highest_cell_index), 4'h0, $past(lowest_cell_index)})
    else $error("Extreme-cell fields misplaced.");

  // Unmapped offsets read zero.
  a_unmapped_zero: assert property (@(posedge clk) disable iff (rst) // [R08]
    (ce && in_check && !write_r && addr_r > 8'h0D) |=> rsp_rdata == 16'h0000)
    else $error("Unmapped read nonzero.");

  // Every request is answered two cycles after capture.
  a_answer_timing: assert property (@(posedge clk) disable iff (rst)
    (ce && state_r == sbwr_pkg::SBWR_IDLE && req_valid) ##1 ce |=> rsp_valid)
    else $error("Answer late.");

  c_write_rejected: cover property (@(posedge clk) disable iff (rst) wr_reject);
  c_write_accepted: cover property (@(posedge clk) disable iff (rst) wr_chain);
  c_status_cleared: cover property (@(posedge clk) disable iff (rst) clr_comm);
endmodule
`default_nettype wire

// File: design/sbwr_regs.svh
// Register offsets, field positions and reset values of the status bank.
// Assumes a 16-bit register word and an 8-bit register address.
`ifndef SBWR_REGS_SVH
`define SBWR_REGS_SVH
`define SBWR_OFF_MODEL_REV    8'h00
`define SBWR_OFF_CHAIN_ADDR   8'h01
`define SBWR_OFF_STAT_PRI     8'h02
`define SBWR_OFF_STAT_COMM    8'h03
`define SBWR_OFF_STAT_BAL     8'h04
`define SBWR_OFF_FAULT_PRI    8'h05
`define SBWR_OFF_FAULT_SEC    8'h06
`define SBWR_OFF_ALERT_SUM    8'h07
`define SBWR_OFF_CELL_OV      8'h08
`define SBWR_OFF_CELL_UV      8'h09
`define SBWR_OFF_EXT_CELL     8'h0A
`define SBWR_OFF_AUX_PROT     8'h0B
`define SBWR_OFF_AUX_OV       8'h0C
`define SBWR_OFF_AUX_UV       8'h0D
`define SBWR_OFF_LAST         8'h0D
`define SBWR_REJECT_BIT       0
`define SBWR_MODEL_LSB        4
`define SBWR_CELL_MASK        16'h7FFE
`define SBWR_AUX_MASK         16'h000F
`define SBWR_EXT_MASK         16'h0F0F
`define SBWR_STAT_BAL_MASK    16'hF800
`define SBWR_FAULT_SEC_MASK   16'hF80F
`define SBWR_ALERT_SUM_MASK   16'hFFDF
`define SBWR_STAT_COMM_MASK   16'hFEFB
`define SBWR_CHAIN_WR_MASK    16'hFFFF
`define SBWR_RESET_WORD       16'h0000
`endif

// File: design/sbwr_pkg.sv
// Types shared by the status bank files.
// Assumes the offsets come from sbwr_regs.svh.
package sbwr_pkg;
  typedef logic [15:0] sbwr_word_t;
  typedef logic [7:0]  sbwr_addr_t;
  // Write handling states, Gray coded along idle, check, done.
  typedef enum logic [1:0] {
    SBWR_IDLE  = 2'b00,
    SBWR_CHECK = 2'b01,
    SBWR_DONE  = 2'b11
  } sbwr_state_t;
endpackage

// File: design/sbwr_hold_reg.sv
// One 16-bit host-writable status word with write-one-to-clear alerts.
// Assumes set pulses come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "sbwr_regs.svh"
module sbwr_hold_reg (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic [15:0]      mask,
  input  wire logic [15:0]      set_bits,
  input  wire logic             clr_en,
  input  wire logic [15:0]      clr_bits,
  output logic      [15:0]      value
);
  logic [15:0] value_nxt;

  // Set wins over clear; unused bits never store.
  assign value_nxt = ((value & ~(clr_en ? clr_bits : 16'h0000)) | set_bits) & mask;

  // Word storage frozen while the clock enable is low.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      value <= `SBWR_RESET_WORD;
    end else if (ce) begin
      value <= value_nxt;
    end
  end
endmodule
`default_nettype wire

// File: tb/sbwr_host_model.sv
// Host controller model issuing single-word requests to the status bank.
// Assumes the bank answers within a few cycles of taking a request.
`timescale 1ns/1ps
`default_nettype none
module sbwr_host_model (
  input  wire logic        clk,
  input  wire logic        rsp_valid,
  input  wire logic [15:0] rsp_rdata,
  input  wire logic        rsp_rejected,
  output var  logic        req_valid,
  output var  logic        req_write,
  output var  logic [7:0]  req_addr,
  output var  logic [15:0] req_wdata
);
  // Request lines start idle.
  initial begin
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr  = 8'h00;
    req_wdata = 16'h0000;
  end

  // Holds a request over its taking edge, then drives inverted lines.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
                      output logic [15:0] q, output logic rj, output logic ok);
    int n;
    ok = 1'b0;
    q = 16'h0000;
    rj = 1'b0;
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr  <= a;
    req_wdata <= d;
    @(posedge clk);
    req_valid <= 1'b0;
    req_write <= ~w;
    req_addr  <= ~a;
    req_wdata <= ~d;
    // The answer is awaited before any new request.
    for (n = 0; n < 8 && !ok; n++) begin
      @(posedge clk);
      #1;
      if (rsp_valid === 1'b1) begin
        q  = rsp_rdata;
        rj = rsp_rejected;
        ok = 1'b1;
      end
    end
  endtask
endmodule
`default_nettype wire

// File: tb/status_bank_write_reject_test.sv
// Self-checking bench for the status bank and its write rejection.
// Assumes the host model answers every request within its bound.
`timescale 1ns/1ps
`default_nettype none
module status_bank_write_reject_test;
  logic clk = 1'b0, rst = 1'b1, bcfg = 1'b0, bsta = 1'b0, ok, rj, al, rv, rr;
  logic [15:0] bal = 16'h0000, sum = 16'h0000, ov = 16'h0000, uv = 16'h0000;
  logic [15:0] q, rd, cfg_m;
  logic [3:0]  hi = 4'h0, lo = 4'h0, ap = 4'h0, ao = 4'h0, au = 4'h0;
  logic        ce_in = 1'b1;
  logic [15:0] pri = 16'h0000;
  logic        qv, qw;
  logic [7:0]  qa;
  logic [15:0] qd;
  int          bad_count = 0, tests_run = 0, seed = 32'h966e, a, i;

  always #5 clk = ~clk;

  sbwr_host_model host (.clk(clk), .rsp_valid(rv), .rsp_rdata(rd), .rsp_rejected(rr),
    .req_valid(qv), .req_write(qw), .req_addr(qa), .req_wdata(qd));

  sbwr_status_bank #(.MODEL_ID(12'hA5C), .REVISION_ID(4'h7)) uut (
    .clk(clk), .rst(rst), .ce(ce_in), .req_valid(qv), .req_write(qw),
    .req_addr(qa), .req_wdata(qd), .busy_config(bcfg), .busy_status(bsta),
    .stat_pri_set(pri), .stat_comm_set(16'h0000), .stat_bal_set(bal),
    .fault_pri_set(16'h0000), .fault_sec_set(16'h0000), .alert_sum_in(sum),
    .cell_over_flags(ov), .cell_under_flags(uv), .highest_cell_index(hi),
    .lowest_cell_index(lo), .aux_prot_in(ap), .aux_over_in(ao), .aux_under_in(au),
    .rsp_valid(rv), .rsp_rdata(rd), .rsp_rejected(rr), .write_reject_alert(al));

  // Prints the verdict and ends the run.
  task automatic wrap_up();
    if (bad_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Compares one seen value with its expectation.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One host transfer; a missing answer ends the run.
  task automatic op(input logic w, input logic [7:0] ad, input logic [15:0] d);
    host.xfer(w, ad, d, q, rj, ok);
    if (ok !== 1'b1) begin
      bad_count++;
      wrap_up();
    end
  endtask

  // Expected read value of the live words, from the field layout.
  function automatic logic [15:0] live_exp(input int ad);
    case (ad)
      7:       live_exp = sum & 16'hFFDF;
      8:       live_exp = ov & 16'h7FFE;
      9:       live_exp = uv & 16'h7FFE;
      10:      live_exp = {4'h0, hi, 4'h0, lo};
      11:      live_exp = {12'h000, ap};
      12:      live_exp = {12'h000, ao};
      13:      live_exp = {12'h000, au};
      default: live_exp = 16'h0000;
    endcase
  endfunction

  // Main sequence; busy inputs stay low except where rejection is exercised.
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    check({15'h0000, al}, 16'h0000);
    op(1'b0, 8'h00, 16'h0000);
    check(q, 16'hA5C7);
    op(1'b1, 8'h00, 16'($random(seed)));
    check({15'h0000, rj}, 16'h0000);
    op(1'b0, 8'h00, 16'h0000);
    check(q, 16'hA5C7);
    cfg_m = 16'($random(seed));
    op(1'b1, 8'h01, cfg_m);
    check({15'h0000, rj}, 16'h0000);
    bcfg <= 1'b1;
    op(1'b1, 8'h01, ~cfg_m);
    check({15'h0000, rj}, 16'h0001);
    check({15'h0000, al}, 16'h0001);
    op(1'b0, 8'h01, 16'h0000);
    check(q, cfg_m);
    bcfg <= 1'b0;
    op(1'b0, 8'h03, 16'h0000);
    check(q, 16'h0001);
    op(1'b1, 8'h03, 16'h0001);
    check({15'h0000, al}, 16'h0000);
    @(posedge clk);
    bal <= 16'hFFFF;
    @(posedge clk);
    bal <= 16'h0000;
    bsta <= 1'b1;
    op(1'b1, 8'h04, 16'hFFFF);
    check({15'h0000, rj}, 16'h0001);
    op(1'b0, 8'h04, 16'h0000);
    check(q, 16'hF800);
    bsta <= 1'b0;
    op(1'b1, 8'h04, 16'hFFFF);
    op(1'b0, 8'h04, 16'h0000);
    check(q, 16'h0000);
    @(posedge clk);
    ce_in <= 1'b0;
    pri   <= 16'h0010;
    @(posedge clk);
    ce_in <= 1'b1;
    pri   <= 16'h0000;
    op(1'b0, 8'h02, 16'h0000);
    check(q, 16'h0000);
    @(posedge clk);
    pri <= 16'h0010;
    @(posedge clk);
    pri <= 16'h0000;
    op(1'b0, 8'h02, 16'h0000);
    check(q, 16'h0010);
    op(1'b1, 8'h02, 16'h0010);
    check({15'h0000, rj}, 16'h0000);
    op(1'b0, 8'h02, 16'h0000);
    check(q, 16'h0000);
    for (i = 0; i < 4; i++) begin
      @(posedge clk);
      {sum, ov} <= $random(seed);
      uv <= 16'($random(seed));
      {hi, lo, ap, ao, au} <= 20'($random(seed));
      for (a = 7; a < 15; a++) begin
        op(1'b0, (a == 14) ? 8'h20 : a[7:0], 16'h0000);
        check(q, live_exp(a));
      end
    end
    wrap_up();
  end
endmodule
`default_nettype wire
